/* logic/aac_pkg.sv */
package aac_pkg;

    // ==========================================================
    // instruction encoding
    localparam logic [7:0] ADD_LIT_OP      = 8'h0F;
    localparam logic [5:0] ADD_FILE_OP     = 6'h09;
    localparam int         DEST_BIT        = 9;
    localparam int         ACCESS_BIT      = 8;
    localparam logic [7:0] INDEX_LIMIT     = 8'h5F;

    // ==========================================================
    // reset values
    localparam logic [7:0] ACC_RESET       = 8'h00;
    localparam logic [4:0] FLAGS_RESET     = 5'h00;
    localparam logic [1:0] PHASE_RESET     = 2'h0;

    // ==========================================================
    // flag positions in the packed flag vector
    localparam int         FLAG_CARRY      = 0;
    localparam int         FLAG_HALF       = 1;
    localparam int         FLAG_ZERO       = 2;
    localparam int         FLAG_RANGE      = 3;
    localparam int         FLAG_NEG        = 4;

    // ==========================================================
    // four phases of one instruction cycle
    typedef enum logic [1:0]
    {
        AAC_DECODE  = 2'b00,
        AAC_READ    = 2'b01,
        AAC_PROCESS = 2'b10,
        AAC_WRITE   = 2'b11
    } aac_phase_t;

    // access bank split: low part of the access bank maps to bank 0
    localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [7:0] ACCESS_SPLIT     = 8'h60;

endpackage

/* logic/aac_adder.sv */
`timescale 1ns/1ps

// ==========================================================
// 8-bit adder with status outputs
module aac_adder
(
    // operands
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] b_i,
    // result
    output logic      [7:0] sum_o,
    output logic            carry_o,
    output logic            half_carry_o,
    output logic            zero_o,
    output logic            range_o,
    output logic            neg_o
);
    wire logic [8:0] full_sum;
    wire logic [4:0] low_sum;

    assign full_sum     = {1'b0, a_i} + {1'b0, b_i};
    assign low_sum      = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
    assign sum_o        = full_sum[7:0];
    assign carry_o      = full_sum[8];
    assign half_carry_o = low_sum[4];
    assign zero_o       = (full_sum[7:0] == 8'h00);
    // same-sign operands giving opposite-sign result
    assign range_o      = (a_i[7] == b_i[7]) && (full_sum[7] != a_i[7]);
    assign neg_o        = full_sum[7];
endmodule

/* logic/aac_exec.sv */
`timescale 1ns/1ps

module aac_exec
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // instruction issue, sampled in the decode phase
    input  wire logic        instr_valid_i,
    input  wire logic [15:0] instr_i,
    input  wire logic        ext_mode_i,
    input  wire logic [3:0]  bank_select_reg_i,
    input  wire logic [7:0]  index_base_i,
    // file register read data, valid in the read phase
    input  wire logic [7:0]  file_rdata_i,
    // file register access
    output logic      [11:0] file_addr_o,
    output logic             file_rd_o,
    output logic             file_we_o,
    output logic      [7:0]  file_wdata_o,
    // architectural state
    output logic      [7:0]  accumulator_reg_o,
    output logic             carry_flag_o,
    output logic             half_carry_flag_o,
    output logic             zero_flag_o,
    output logic             signed_range_flag_o,
    output logic             negative_flag_o,
    output logic             phase_decode_o,
    output logic             busy_o
);
    import aac_pkg::*;

    // ==========================================================
    // state
    aac_phase_t  phase_r;
    aac_phase_t  phase_nxt;
    logic [15:0] instr_r;
    logic        ext_r;
    logic [3:0]  bank_r;
    logic [7:0]  base_r;
    logic        live_r;
    logic [7:0]  operand_r;
    logic [7:0]  sum_r;
    logic [4:0]  stat_r;
    logic [7:0]  acc_r;
    logic [7:0]  acc_nxt;
    logic [4:0]  flags_r;
    logic [4:0]  flags_nxt;
    logic [11:0] addr_r;
    logic        rd_r;
    logic        we_r;
    logic [7:0]  wdata_r;
    logic        pd_r;
    logic        busy_r;

    // ==========================================================
    // decode
    wire logic        is_lit;
    wire logic        is_file;
    wire logic        dest_file;
    wire logic        access_clr;
    wire logic        use_index;
    wire logic [7:0]  freg;
    wire logic [11:0] eff_addr;
    wire logic [7:0]  idx_sum;
    wire logic [7:0]  b_operand;
    wire logic [7:0]  add_sum;
    wire logic [4:0]  add_stat;

    assign is_lit     = live_r && (instr_r[15:8] == ADD_LIT_OP);
    assign is_file    = live_r && (instr_r[15:10] == ADD_FILE_OP);
    assign dest_file  = instr_r[DEST_BIT];
    assign access_clr = !instr_r[ACCESS_BIT];
    assign freg       = instr_r[7:0];
    assign use_index  = access_clr && ext_r && (freg <= INDEX_LIMIT);
    assign idx_sum    = 8'(base_r + freg);
    // indexed offsets wrap within one page; full pointer math lives elsewhere
    assign eff_addr   = use_index ? {bank_r, idx_sum}
                      : !access_clr ? {bank_r, freg}
                      : (freg < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, freg}
                      : {ACCESS_HIGH_BANK, freg};
    assign b_operand  = is_file ? operand_r : freg;

    aac_adder u_add
    (
        .a_i          (acc_r),
        .b_i          (b_operand),
        .sum_o        (add_sum),
        .carry_o      (add_stat[FLAG_CARRY]),
        .half_carry_o (add_stat[FLAG_HALF]),
        .zero_o       (add_stat[FLAG_ZERO]),
        .range_o      (add_stat[FLAG_RANGE]),
        .neg_o        (add_stat[FLAG_NEG])
    );

    // ==========================================================
    // phase sequencing, four phases per instruction
    always_comb
    begin
        case (phase_r)
            AAC_DECODE:  phase_nxt = AAC_READ;
            AAC_READ:    phase_nxt = AAC_PROCESS;
            AAC_PROCESS: phase_nxt = AAC_WRITE;
            AAC_WRITE:   phase_nxt = AAC_DECODE;
            default:     phase_nxt = AAC_DECODE;
        endcase
    end

    // accumulator written in the write phase of a valid add unless the file is the target
    assign acc_nxt   = (phase_r == AAC_WRITE) && (is_lit || (is_file && !dest_file))
                     ? sum_r : acc_r;
    assign flags_nxt = (phase_r == AAC_WRITE) && (is_lit || is_file) ? stat_r : flags_r;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            phase_r   <= AAC_DECODE;
            instr_r   <= 16'h0000;
            ext_r     <= 1'b0;
            bank_r    <= 4'h0;
            base_r    <= 8'h00;
            live_r    <= 1'b0;
            operand_r <= 8'h00;
            sum_r     <= 8'h00;
            stat_r    <= FLAGS_RESET;
            acc_r     <= ACC_RESET;
            flags_r   <= FLAGS_RESET;
            addr_r    <= 12'h000;
            rd_r      <= 1'b0;
            we_r      <= 1'b0;
            wdata_r   <= 8'h00;
            pd_r      <= 1'b0;
            busy_r    <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            acc_r   <= acc_nxt;
            flags_r <= flags_nxt;
            pd_r    <= (phase_nxt == AAC_DECODE);
            rd_r    <= 1'b0;
            we_r    <= 1'b0;
            if (phase_r == AAC_DECODE)
            begin
                instr_r <= instr_i;
                live_r  <= instr_valid_i;
                ext_r   <= ext_mode_i;
                bank_r  <= bank_select_reg_i;
                base_r  <= index_base_i;
                busy_r  <= instr_valid_i;
            end
            if (phase_r == AAC_READ)
            begin
                operand_r <= file_rdata_i;
            end
            if (phase_r == AAC_PROCESS)
            begin
                sum_r  <= add_sum;
                stat_r <= add_stat;
            end
            if (phase_r == AAC_WRITE)
            begin
                busy_r <= 1'b0;
            end
            // read strobed during the read phase; address is zero then and presented in the process phase
            if (phase_nxt == AAC_READ)
            begin
                addr_r <= 12'h000;
            end
            if (phase_r == AAC_DECODE)
            begin
                rd_r   <= instr_valid_i && (instr_i[15:10] == ADD_FILE_OP);
            end
            if (phase_r == AAC_READ)
            begin
                addr_r <= eff_addr;
            end
            // write strobe comes out in the decode phase after the write phase
            if (phase_r == AAC_WRITE)
            begin
                we_r    <= is_file && dest_file;
                wdata_r <= sum_r;
            end
        end
    end

    assign file_addr_o         = addr_r;
    assign file_rd_o           = rd_r;
    assign file_we_o           = we_r;
    assign file_wdata_o        = wdata_r;
    assign accumulator_reg_o   = acc_r;
    assign carry_flag_o        = flags_r[FLAG_CARRY];
    assign half_carry_flag_o   = flags_r[FLAG_HALF];
    assign zero_flag_o         = flags_r[FLAG_ZERO];
    assign signed_range_flag_o = flags_r[FLAG_RANGE];
    assign negative_flag_o     = flags_r[FLAG_NEG];
    assign phase_decode_o      = pd_r;
    assign busy_o              = busy_r;

    // ==========================================================
    // checks
    a_lit_acc_update: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (phase_r == AAC_WRITE && is_lit) |=> (acc_r == $past(sum_r)))
        else $error("literal add did not load accumulator");
    a_dest_keeps_acc: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (phase_r == AAC_WRITE && is_file && dest_file) |=> (we_r && $stable(acc_r)))
        else $error("file destination disturbed accumulator");
    a_acc_dest_nowr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (phase_r == AAC_WRITE && is_file && !dest_file) |=> !we_r)
        else $error("accumulator destination wrote file");
    a_acc_dest_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (phase_r == AAC_WRITE && is_file && !dest_file) |=> (acc_r == $past(sum_r)))
        else $error("accumulator destination not loaded");
    a_index_addr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (phase_r == AAC_READ && ext_r && access_clr && freg <= INDEX_LIMIT)
        |=> (addr_r == {$past(bank_r), 8'($past(base_r) + $past(freg))}))
        else $error("indexed address wrong");
    a_index_gate: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (phase_r == AAC_READ && !(ext_r && access_clr && freg <= INDEX_LIMIT))
        |=> (addr_r[7:0] == $past(freg)))
        else $error("indexed mode outside its conditions");
    a_bank_addr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (phase_r == AAC_READ && !access_clr) |=> (addr_r == {$past(bank_r), $past(freg)}))
        else $error("banked address wrong");
    a_file_read: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (phase_r == AAC_DECODE && instr_valid_i && instr_i[15:10] == 6'h09) |=> rd_r ##1 rd_r == 1'b0)
        else $error("file read strobe missing");
    a_one_cycle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (phase_r == AAC_DECODE) |=> (phase_r == AAC_READ) ##1 (phase_r == AAC_PROCESS)
        ##1 (phase_r == AAC_WRITE) ##1 (phase_r == AAC_DECODE))
        else $error("instruction cycle not four phases");
endmodule

/* sim/aac_exec_tb.sv */
`timescale 1ns/1ps

module testbench;
    import aac_pkg::*;

    // ==========================================================
    // stimulus and observed ports
    logic        clock_i           = 1'b0;
    logic        sys_rst_i         = 1'b1;
    logic        instr_valid_i     = 1'b0;
    logic [15:0] instr_i           = 16'h0000;
    logic        ext_mode_i        = 1'b0;
    logic [3:0]  bank_select_reg_i = 4'h0;
    logic [7:0]  index_base_i      = 8'h00;
    logic [7:0]  file_rdata_i      = 8'h00;
    logic [11:0] file_addr_o;
    logic        file_rd_o;
    logic        file_we_o;
    logic [7:0]  file_wdata_o;
    logic [7:0]  accumulator_reg_o;
    logic        carry_flag_o;
    logic        half_carry_flag_o;
    logic        zero_flag_o;
    logic        signed_range_flag_o;
    logic        negative_flag_o;
    logic        phase_decode_o;
    logic        busy_o;
    logic [4:0]  flags_w;
    logic [7:0]  acc_m             = 8'h00;
    logic [4:0]  flags_m           = 5'h00;
    int          failures          = 0;
    int          n_tests           = 0;
    int          cycles            = 0;

    assign flags_w = {negative_flag_o, signed_range_flag_o, zero_flag_o, half_carry_flag_o, carry_flag_o};

    aac_exec aac_exec_inst
    (
        .clock_i             (clock_i),
        .sys_rst_i           (sys_rst_i),
        .instr_valid_i       (instr_valid_i),
        .instr_i             (instr_i),
        .ext_mode_i          (ext_mode_i),
        .bank_select_reg_i   (bank_select_reg_i),
        .index_base_i        (index_base_i),
        .file_rdata_i        (file_rdata_i),
        .file_addr_o         (file_addr_o),
        .file_rd_o           (file_rd_o),
        .file_we_o           (file_we_o),
        .file_wdata_o        (file_wdata_o),
        .accumulator_reg_o   (accumulator_reg_o),
        .carry_flag_o        (carry_flag_o),
        .half_carry_flag_o   (half_carry_flag_o),
        .zero_flag_o         (zero_flag_o),
        .signed_range_flag_o (signed_range_flag_o),
        .negative_flag_o     (negative_flag_o),
        .phase_decode_o      (phase_decode_o),
        .busy_o              (busy_o)
    );

    // ==========================================================
    // clock and hang guard
    always #50 clock_i = ~clock_i;

    always @(posedge clock_i)
    begin
        cycles++;
        // about 15 instructions of 4 cycles need far less
        if (cycles == 1000)
        begin
            failures++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ==========================================================
    // one instruction issued in decode, judged in the next decode
    task automatic run_op(input logic [15:0] ins, input logic vld, input logic ext,
                          input logic [3:0] bank_select_reg, input logic [7:0] idx, input logic [7:0] fdat);
        logic        is_lit;
        logic        is_file;
        logic [7:0]  f;
        logic [7:0]  b;
        logic [8:0]  s;
        logic [11:0] ea;
        logic [4:0]  fl;
        int          guard;
        is_lit  = vld && ins[15:8] == 8'h0F;
        is_file = vld && ins[15:10] == 6'h09;
        f       = ins[7:0];
        b       = is_lit ? f : fdat;
        s       = {1'b0, acc_m} + {1'b0, b};
        ea      = ins[8] ? {bank_select_reg, f} : (ext && f <= 8'h5F) ? {bank_select_reg, 8'(idx + f)} :
                  {(f < 8'h60 ? 4'h0 : 4'hF), f};
        fl      = {s[7], (acc_m[7] == b[7]) && (s[7] != acc_m[7]), s[7:0] == 8'h00,
                   ({1'b0, acc_m[3:0]} + {1'b0, b[3:0]}) > 5'h0F, s[8]};
        guard   = 0;
        while (phase_decode_o !== 1'b1 && guard < 8)
        begin
            @(negedge clock_i);
            guard++;
        end
        instr_i           = ins;
        instr_valid_i     = vld;
        ext_mode_i        = ext;
        bank_select_reg_i = bank_select_reg;
        index_base_i      = idx;
        file_rdata_i      = fdat;
        @(negedge clock_i);
        instr_valid_i = 1'b0;
        chk("file_rd_o", is_file, file_rd_o);
        chk("busy_o", vld, busy_o);
        chk("phase_decode_o", 1'b0, phase_decode_o);
        repeat (3) @(negedge clock_i);
        chk("busy_o idle", 1'b0, busy_o);
        chk("phase_decode_o", 1'b1, phase_decode_o);
        if (is_lit || (is_file && !ins[9]))
            acc_m = s[7:0];
        if (is_lit || is_file)
            flags_m = fl;
        chk("accumulator", acc_m, accumulator_reg_o);
        chk("flags", flags_m, flags_w);
        chk("file_we_o", is_file && ins[9], file_we_o);
        if (is_file)
            chk("file_addr_o", ea, file_addr_o);
        if (is_file && ins[9])
            chk("file_wdata_o", s[7:0], file_wdata_o);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_literal();
        run_op(16'h0F10, 1'b1, 1'b0, 4'h0, 8'h00, 8'h00);
        run_op(16'h0F15, 1'b1, 1'b0, 4'h0, 8'h00, 8'h00);
        chk("literal sum", 8'h25, accumulator_reg_o);
        run_op(16'h0F5B, 1'b1, 1'b0, 4'h0, 8'h00, 8'h00);
        run_op(16'h0F80, 1'b1, 1'b0, 4'h0, 8'h00, 8'h00);
        run_op(16'h0F0F, 1'b1, 1'b0, 4'h0, 8'h00, 8'h01);
    endtask

    task automatic t_file_dest();
        run_op(16'h2430, 1'b1, 1'b0, 4'h5, 8'h00, 8'hC2);
        run_op(16'h2780, 1'b1, 1'b0, 4'h5, 8'h00, 8'h7F);
        run_op(16'h2680, 1'b1, 1'b1, 4'h5, 8'h00, 8'h01);
    endtask

    task automatic t_index();
        run_op(16'h265F, 1'b1, 1'b1, 4'h3, 8'hA5, 8'h10);
        run_op(16'h2660, 1'b1, 1'b1, 4'h3, 8'hA5, 8'h20);
        run_op(16'h245F, 1'b1, 1'b0, 4'h3, 8'hA5, 8'h33);
        run_op(16'h2500, 1'b1, 1'b1, 4'h9, 8'hA5, 8'hFF);
    endtask

    task automatic t_ignored();
        run_op(16'h0B55, 1'b1, 1'b0, 4'h0, 8'h00, 8'h00);
        run_op(16'h2155, 1'b1, 1'b0, 4'h0, 8'h00, 8'h11);
        run_op(16'h0F01, 1'b0, 1'b0, 4'h0, 8'h00, 8'h00);
    endtask

    initial
    begin
        repeat (4) @(negedge clock_i);
        sys_rst_i = 1'b0;
        chk("acc after reset", 8'h00, accumulator_reg_o);
        chk("flags after reset", 5'h00, flags_w);
        t_literal();
        t_file_dest();
        t_index();
        t_ignored();
        final_report();
    end
endmodule
